// File: src/fault_pkg.sv
// Shared constants and types for the overcurrent and thermal supervision block.
// Assumes a 200 MHz system clock and 8-bit supply-ratio codes from on-chip samplers.
package fault_pkg;
	localparam int CLK_PERIOD_NS = 5;
	localparam int NUM_PH = 4;
	localparam int CUR_W = 10;
	// Current reference in microamps; the current codes are 1 uA per step.
	localparam int OC_REF_UA = 100;
	localparam logic [CUR_W-1:0] OC_REF_CODE = CUR_W'(OC_REF_UA);
	localparam logic [3:0] PH_TRIP_CYCLES = 4'h8;
	localparam logic [12:0] HICCUP_CYCLES = 13'h1000;
	localparam int SHUTDOWN_NS = 20;
	localparam int SHUTDOWN_CYC = SHUTDOWN_NS / CLK_PERIOD_NS;
	localparam int STARTUP_DELAY_NS = 1360000;
	localparam int STARTUP_DELAY_CYC = STARTUP_DELAY_NS / CLK_PERIOD_NS;
	// Thermal thresholds as percent of supply and as 8-bit ratio codes.
	localparam int FAN_LO_PCT = 33;
	localparam int FAN_HI_PCT = 39;
	localparam int HOT_LO_PCT = 28;
	localparam int HOT_HI_PCT = 33;
	localparam logic [7:0] FAN_LO_CODE = 8'(FAN_LO_PCT * 256 / 100);
	localparam logic [7:0] FAN_HI_CODE = 8'(FAN_HI_PCT * 256 / 100);
	localparam logic [7:0] HOT_LO_CODE = 8'(HOT_LO_PCT * 256 / 100);
	localparam logic [7:0] HOT_HI_CODE = 8'(HOT_HI_PCT * 256 / 100);
	// Compensation is on at or above one fifteenth of supply.
	localparam logic [7:0] COMP_EN_CODE = 8'((256 + 14) / 15);
	localparam logic [3:0] COMP_MID = 4'h4;
	localparam logic [10:0] GAIN_UNITY = 11'h400;
	// Register byte offsets.
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_IRQ_EN = 8'h04;
	localparam logic [7:0] REG_IRQ_CLR = 8'h08;
	localparam logic [7:0] REG_CTRL = 8'h0C;
	localparam logic [7:0] REG_STATE = 8'h10;
	localparam logic [3:0] IRQ_EN_RST = 4'h0;
	localparam logic CTRL_RST = 1'b1;
	localparam int EV_OC_AVG = 0;
	localparam int EV_OC_PH = 1;
	localparam int EV_FAN = 2;
	localparam int EV_HOT = 3;

	typedef enum logic [1:0] {ST_OFF, ST_DELAY, ST_RUN, ST_HICCUP} seq_state_t;

	typedef struct packed {
		seq_state_t st;
		logic [18:0] dly_cnt;
		logic [12:0] hic_cnt;
		logic [NUM_PH*4-1:0] ph_cnt;
		logic en_s1;
		logic en_s2;
		logic fan_hot;
		logic hot_hot;
		logic [NUM_PH-1:0] pwm_out;
		logic pwm_oe;
		logic [3:0] status;
		logic [3:0] irq_en;
		logic ctrl_en;
		logic [31:0] prdata;
		logic pslverr;
	} fault_state_t;
endpackage

// File: src/fault_supervisor.sv
// Overcurrent hiccup sequencer, thermal flags, temperature compensation and APB registers.
// Assumes phase currents, sense codes and PWM requests come from logic on clk;
// the controller enable arrives from a pin and is synchronised here.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module fault_supervisor
	import fault_pkg::*;
#(
	parameter int STARTUP_CYC = STARTUP_DELAY_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ctrl_enable,
	input wire logic sw_cycle,
	input wire logic [NUM_PH*CUR_W-1:0] phase_current,
	input wire logic [7:0] temp_sense_input,
	input wire logic [7:0] comp_factor_setting,
	input wire logic [NUM_PH-1:0] pwm_req,
	output logic [NUM_PH-1:0] pwm_out,
	output logic [NUM_PH-1:0] pwm_oe,
	output logic ramp_start,
	output logic [NUM_PH*CUR_W-1:0] comp_current,
	output logic cooling_request_flag_out,
	output logic cooling_request_flag_oe,
	output logic overtemp_flag_out,
	output logic overtemp_flag_oe,
	output logic irq,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	fault_state_t s_r, s_nxt;
	logic [5:0] temp_code;
	logic [3:0] factor;
	logic comp_on;
	logic [10:0] gain;
	logic [CUR_W+1:0] cur_sum;
	logic oc_avg;
	logic [NUM_PH-1:0] ph_trip;
	logic oc_ph;
	logic enabled;
	logic [3:0] ev;

	// Lower sense voltage means a hotter sensor, so the code is inverted.
	function automatic logic [5:0] to_temp_code(input logic [7:0] ratio);
		to_temp_code = 6'h3F - ratio[7:2];
	endfunction

	function automatic logic [CUR_W-1:0] scale(input logic [CUR_W-1:0] i, input logic [10:0] g);
		logic [CUR_W+10:0] p;
		p = i * g;
		scale = p[CUR_W+9:10];
	endfunction

	always_comb begin
		temp_code = to_temp_code(temp_sense_input);
		comp_on = comp_factor_setting >= COMP_EN_CODE;
		factor = 4'h0;
		if (comp_on) begin
			factor = comp_factor_setting[7:4];
			if (factor == 4'h0) begin
				factor = 4'h1;
			end
		end
		// Larger factors pull the gain further down as the sensor reads hotter.
		gain = GAIN_UNITY - 11'(temp_code * factor);
		if (factor == 4'h0) begin
			gain = GAIN_UNITY;
		end
	end

	always_comb begin
		cur_sum = '0;
		for (int p = 0; p < NUM_PH; p++) begin
			comp_current[p*CUR_W +: CUR_W] = scale(phase_current[p*CUR_W +: CUR_W], gain);
			cur_sum = cur_sum + (CUR_W+2)'(comp_current[p*CUR_W +: CUR_W]);
		end
	end

	assign oc_avg = cur_sum[CUR_W+1:2] > OC_REF_CODE;

	always_comb begin
		for (int p = 0; p < NUM_PH; p++) begin
			ph_trip[p] = sw_cycle && comp_current[p*CUR_W +: CUR_W] > OC_REF_CODE
				&& s_r.ph_cnt[p*4 +: 4] == PH_TRIP_CYCLES - 4'h1;
		end
	end

	assign oc_ph = |ph_trip;
	assign enabled = s_r.en_s2 & s_r.ctrl_en;

	always_comb begin
		s_nxt = s_r;
		s_nxt.en_s1 = ctrl_enable;
		s_nxt.en_s2 = s_r.en_s1;
		s_nxt.pslverr = 1'b0;
		ramp_start = 1'b0;
		ev = '0;
		if (sw_cycle) begin
			for (int p = 0; p < NUM_PH; p++) begin
				if (comp_current[p*CUR_W +: CUR_W] > OC_REF_CODE && s_r.st == ST_RUN) begin
					s_nxt.ph_cnt[p*4 +: 4] = s_r.ph_cnt[p*4 +: 4] + 4'h1;
				end else begin
					s_nxt.ph_cnt[p*4 +: 4] = 4'h0;
				end
			end
		end
		case (s_r.st)
			ST_OFF: begin
				if (enabled) begin
					s_nxt.st = ST_DELAY;
					s_nxt.dly_cnt = '0;
				end
			end
			ST_DELAY: begin
				if (!enabled) begin
					s_nxt.st = ST_OFF;
				end else if (s_r.dly_cnt == 19'(STARTUP_CYC - 1)) begin
					s_nxt.st = ST_RUN;
					ramp_start = 1'b1;
				end else begin
					s_nxt.dly_cnt = s_r.dly_cnt + 19'h1;
				end
			end
			ST_RUN: begin
				if (!enabled) begin
					s_nxt.st = ST_OFF;
				end else if (oc_avg || oc_ph) begin
					s_nxt.st = ST_HICCUP;
					s_nxt.hic_cnt = '0;
					s_nxt.ph_cnt = '0;
					ev[EV_OC_AVG] = oc_avg;
					ev[EV_OC_PH] = oc_ph;
				end
			end
			ST_HICCUP: begin
				if (sw_cycle) begin
					s_nxt.hic_cnt = s_r.hic_cnt + 13'h1;
				end
				if (s_r.hic_cnt == HICCUP_CYCLES) begin
					s_nxt.st = enabled ? ST_DELAY : ST_OFF;
					s_nxt.dly_cnt = '0;
				end
			end
			default: begin
				s_nxt.st = ST_OFF;
			end
		endcase
		// Outputs drive only in RUN and stop the cycle after a trip is seen.
		s_nxt.pwm_oe = s_nxt.st == ST_RUN;
		s_nxt.pwm_out = s_nxt.pwm_oe ? pwm_req : '0;
		if (temp_sense_input < FAN_LO_CODE) begin
			s_nxt.fan_hot = 1'b1;
		end else if (temp_sense_input > FAN_HI_CODE) begin
			s_nxt.fan_hot = 1'b0;
		end
		if (temp_sense_input < HOT_LO_CODE) begin
			s_nxt.hot_hot = 1'b1;
		end else if (temp_sense_input > HOT_HI_CODE) begin
			s_nxt.hot_hot = 1'b0;
		end
		ev[EV_FAN] = s_nxt.fan_hot & ~s_r.fan_hot;
		ev[EV_HOT] = s_nxt.hot_hot & ~s_r.hot_hot;
		if (psel && penable && pwrite) begin
			case (paddr)
				REG_IRQ_EN: s_nxt.irq_en = pwdata[3:0];
				REG_IRQ_CLR: s_nxt.status = s_r.status & ~pwdata[3:0];
				REG_CTRL: s_nxt.ctrl_en = pwdata[0];
				default: s_nxt.pslverr = s_r.pslverr;
			endcase
		end
		// A new event wins over a clear in the same cycle.
		s_nxt.status = s_nxt.status | ev;
		if (psel && !penable) begin
			case (paddr)
				REG_STATUS: s_nxt.prdata = {28'h0000000, s_r.status};
				REG_IRQ_EN: s_nxt.prdata = {28'h0000000, s_r.irq_en};
				REG_IRQ_CLR: s_nxt.prdata = 32'h00000000;
				REG_CTRL: s_nxt.prdata = {31'h00000000, s_r.ctrl_en};
				REG_STATE: s_nxt.prdata = {12'h000, s_r.hot_hot, s_r.fan_hot, comp_on, 1'b0,
					factor, 2'h0, temp_code, 2'h0, s_r.st};
				default: s_nxt.prdata = 32'h00000000;
			endcase
			if (paddr != REG_STATUS && paddr != REG_IRQ_EN && paddr != REG_IRQ_CLR
				&& paddr != REG_CTRL && paddr != REG_STATE) begin
				s_nxt.pslverr = 1'b1;
			end
		end else if (psel && penable) begin
			s_nxt.pslverr = s_r.pslverr;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '{st: ST_OFF, dly_cnt: '0, hic_cnt: '0, ph_cnt: '0, en_s1: 1'b0, en_s2: 1'b0,
				fan_hot: 1'b0, hot_hot: 1'b0, pwm_out: '0, pwm_oe: 1'b0, status: '0,
				irq_en: IRQ_EN_RST, ctrl_en: CTRL_RST, prdata: '0, pslverr: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pwm_out = s_r.pwm_out;
	assign pwm_oe = {NUM_PH{s_r.pwm_oe}};
	assign cooling_request_flag_out = 1'b0;
	assign cooling_request_flag_oe = ~s_r.fan_hot;
	assign overtemp_flag_out = 1'b0;
	assign overtemp_flag_oe = ~s_r.hot_hot;
	assign irq = |(s_r.status & s_r.irq_en);
	assign prdata = s_r.prdata;
	assign pready = psel & penable;
	assign pslverr = s_r.pslverr & psel & penable;

	property p_avg_trip;
		@(posedge clk) disable iff (!rst_n)
		(s_r.st == ST_RUN && enabled && oc_avg) |=> s_r.st == ST_HICCUP && s_r.status[EV_OC_AVG];
	endproperty
	a_avg_trip: assert property (p_avg_trip) else $error("average overcurrent did not trip");

	property p_phase_trip;
		@(posedge clk) disable iff (!rst_n)
		(s_r.st == ST_RUN && enabled && oc_ph) |=> s_r.st == ST_HICCUP && s_r.status[EV_OC_PH];
	endproperty
	a_phase_trip: assert property (p_phase_trip) else $error("phase overcurrent did not trip");

	property p_cnt_clear;
		@(posedge clk) disable iff (!rst_n)
		(sw_cycle && comp_current[CUR_W-1:0] <= OC_REF_CODE) |=> s_r.ph_cnt[3:0] == 4'h0;
	endproperty
	a_cnt_clear: assert property (p_cnt_clear) else $error("phase counter not cleared");

	property p_release;
		@(posedge clk) disable iff (!rst_n)
		$rose(s_r.st == ST_HICCUP) |-> ##[0:3] pwm_oe == '0;
	endproperty
	a_release: assert property (p_release) else $error("outputs not released after trip");

	property p_hold_off;
		@(posedge clk) disable iff (!rst_n)
		(s_r.st == ST_HICCUP && s_r.hic_cnt < HICCUP_CYCLES) |=> s_r.st == ST_HICCUP && pwm_oe == '0;
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("left hiccup wait early");

	property p_retry;
		@(posedge clk) disable iff (!rst_n)
		(s_r.st == ST_HICCUP && s_r.hic_cnt == HICCUP_CYCLES) |=>
			s_r.st == ($past(enabled) ? ST_DELAY : ST_OFF);
	endproperty
	a_retry: assert property (p_retry) else $error("wrong state after hiccup wait");

	property p_fan_hyst;
		@(posedge clk) disable iff (!rst_n)
		(temp_sense_input < FAN_LO_CODE) |=> !cooling_request_flag_oe && !cooling_request_flag_out;
	endproperty
	a_fan_hyst: assert property (p_fan_hyst) else $error("cooling flag not released");

	property p_hot_hyst;
		@(posedge clk) disable iff (!rst_n)
		(temp_sense_input > HOT_HI_CODE) |=> overtemp_flag_oe;
	endproperty
	a_hot_hyst: assert property (p_hot_hyst) else $error("overtemp flag not pulled low");

	property p_zero_factor;
		@(posedge clk) disable iff (!rst_n)
		(comp_factor_setting < COMP_EN_CODE) |-> comp_current == phase_current;
	endproperty
	a_zero_factor: assert property (p_zero_factor) else $error("gain applied while disabled");

	property p_delay;
		@(posedge clk) disable iff (!rst_n)
		(s_r.st == ST_DELAY && s_r.dly_cnt < 19'(STARTUP_CYC - 1) && enabled) |=> s_r.st == ST_DELAY;
	endproperty
	a_delay: assert property (p_delay) else $error("ramp began before startup delay");

	property p_ramp_run;
		@(posedge clk) disable iff (!rst_n)
		ramp_start |=> s_r.st == ST_RUN && pwm_oe == '1;
	endproperty
	a_ramp_run: assert property (p_ramp_run) else $error("ramp without run");

	property p_oe_run;
		@(posedge clk) disable iff (!rst_n)
		(s_r.st != ST_RUN) |-> pwm_oe == '0;
	endproperty
	a_oe_run: assert property (p_oe_run) else $error("outputs driven outside run");

	property p_out_quiet;
		@(posedge clk) disable iff (!rst_n)
		(pwm_oe == '0) |-> pwm_out == '0;
	endproperty
	a_out_quiet: assert property (p_out_quiet) else $error("released phase not low");

	property p_ph_count;
		@(posedge clk) disable iff (!rst_n)
		(sw_cycle && s_r.st == ST_RUN && comp_current[CUR_W-1:0] > OC_REF_CODE
			&& !oc_avg && !oc_ph) |=> s_r.ph_cnt[3:0] == $past(s_r.ph_cnt[3:0]) + 4'h1;
	endproperty
	a_ph_count: assert property (p_ph_count) else $error("phase run count stalled");

	property p_no_early;
		@(posedge clk) disable iff (!rst_n)
		(s_r.st == ST_RUN && enabled && !oc_avg && !oc_ph) |=> s_r.st == ST_RUN;
	endproperty
	a_no_early: assert property (p_no_early) else $error("left run without cause");

	property p_hic_count;
		@(posedge clk) disable iff (!rst_n)
		(s_r.st == ST_HICCUP && sw_cycle && s_r.hic_cnt < HICCUP_CYCLES) |=>
			s_r.hic_cnt == $past(s_r.hic_cnt) + 13'h1;
	endproperty
	a_hic_count: assert property (p_hic_count) else $error("hiccup count stalled");

	property p_fan_pull;
		@(posedge clk) disable iff (!rst_n)
		(temp_sense_input > FAN_HI_CODE) |=> cooling_request_flag_oe;
	endproperty
	a_fan_pull: assert property (p_fan_pull) else $error("cooling flag not pulled low");

	property p_hot_release;
		@(posedge clk) disable iff (!rst_n)
		(temp_sense_input < HOT_LO_CODE) |=> !overtemp_flag_oe && !overtemp_flag_out;
	endproperty
	a_hot_release: assert property (p_hot_release) else $error("overtemp not released");

	property p_oc_sticky;
		@(posedge clk) disable iff (!rst_n)
		(s_r.status[EV_OC_AVG] && !(psel && penable && pwrite && paddr == REG_IRQ_CLR))
			|=> s_r.status[EV_OC_AVG];
	endproperty
	a_oc_sticky: assert property (p_oc_sticky) else $error("overcurrent event lost");

	property p_comp_cut;
		@(posedge clk) disable iff (!rst_n)
		(comp_factor_setting >= COMP_EN_CODE) |-> comp_current[CUR_W-1:0] <= phase_current[CUR_W-1:0];
	endproperty
	a_comp_cut: assert property (p_comp_cut) else $error("gain raised a current");
endmodule
`default_nettype wire

// File: bench/drive_pull_model.sv
// Gate-driver and pull-up model at the phase and flag outputs.
// Assumes the supervisor's split out and enable pins.
`timescale 1ns/10ps
`default_nettype none
module drive_pull_model (
	input wire logic [3:0] pwm_out,
	input wire logic [3:0] pwm_oe,
	input wire logic fan_out,
	input wire logic fan_oe,
	input wire logic hot_out,
	input wire logic hot_oe,
	output logic [3:0] both_off,
	output logic fan_wire,
	output logic hot_wire
);
	// A released phase turns off both switches of its driver.
	assign both_off = ~pwm_oe;
	assign fan_wire = fan_oe ? fan_out : 1'b1;
	assign hot_wire = hot_oe ? hot_out : 1'b1;
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the fault supervisor.
// Assumes fault_pkg and the driver model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import fault_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic en = 1'b0;
	logic sw = 1'b0;
	logic [39:0] cur = '0;
	logic [7:0] tm = 8'hC0;
	logic [7:0] cf = 8'h00;
	logic [3:0] req = 4'h0;
	logic [3:0] pout, poe, off;
	logic [39:0] ccur;
	logic fo, foe, ho, hoe, fw, hw, irq;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, e;
	int num_errors = 0;
	int samples_checked = 0;
	always #2.5 clk = ~clk;
	fault_supervisor #(.STARTUP_CYC(20)) i_dut (.clk(clk), .rst_n(rst_n), .ctrl_enable(en),
		.sw_cycle(sw), .phase_current(cur), .temp_sense_input(tm),
		.comp_factor_setting(cf), .pwm_req(req), .pwm_out(pout), .pwm_oe(poe),
		.ramp_start(), .comp_current(ccur), .cooling_request_flag_out(fo),
		.cooling_request_flag_oe(foe), .overtemp_flag_out(ho), .overtemp_flag_oe(hoe),
		.irq(irq), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	drive_pull_model i_drv (.pwm_out(pout), .pwm_oe(poe), .fan_out(fo), .fan_oe(foe),
		.hot_out(ho), .hot_oe(hoe), .both_off(off), .fan_wire(fw), .hot_wire(hw));
	task automatic check(input string n, input logic [39:0] s, input logic [39:0] x);
		samples_checked++;
		if (s !== x) begin
			num_errors++;
			$display("FAIL %s expected %0h seen %0h", n, x, s);
		end
	endtask
	task automatic conclude();
		$display("checked %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			num_errors++;
			conclude();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		check("prdata", q, x);
	endtask
	task automatic settle(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic pulses(input int k);
		repeat (k) begin
			@(posedge clk);
			sw <= 1'b1;
			@(posedge clk);
			sw <= 1'b0;
		end
	endtask
	task automatic wait_oe(input logic [3:0] v, input int b);
		int n;
		n = 0;
		#1;
		while (poe !== v && n < b) begin
			settle(1);
			n++;
		end
		check("pwm_oe", poe, v);
	endtask
	task automatic temp(input logic [7:0] v, input logic f, input logic h);
		@(posedge clk) tm <= v;
		settle(4);
		check("fan", fw, f);
		check("hot", hw, h);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		settle(1);
		check("pwm_oe", poe, 4'h0);
		check("fan", fw, 1'b0);
		check("hot", hw, 1'b0);
		rd(REG_CTRL, 32'h1);
		rd(8'h20, 32'h0);
		check("pslverr", e, 1'b1);
		apb(1'b1, 8'h20, 32'hF);
		check("pslverr_wr", e, 1'b1);
		rd(REG_IRQ_EN, 32'h0);
		@(posedge clk) cur <= {4{10'd100}};
		settle(3);
		check("comp0", ccur[9:0], 10'd100);
		@(posedge clk) cf <= 8'h10;
		settle(3);
		check("comp_off", ccur[9:0], 10'd100);
		@(posedge clk) cf <= 8'h40;
		settle(3);
		check("comp4", ccur[9:0], 10'd94);
		rd(REG_STATE, 32'h000240F0);
		@(posedge clk) cf <= 8'hF0;
		settle(3);
		check("comp15", ccur[39:30], 10'd78);
		@(posedge clk) begin
			cur <= '0;
			cf <= 8'h00;
			en <= 1'b1;
			req <= 4'hA;
		end
		settle(18);
		check("pwm_oe", poe, 4'h0);
		wait_oe(4'hF, 12);
		settle(1);
		check("pwm_out", pout, 4'hA);
		apb(1'b1, REG_IRQ_EN, 32'h3);
		@(posedge clk) cur <= {4{10'd100}};
		settle(4);
		check("pwm_oe", poe, 4'hF);
		@(posedge clk) cur <= {4{10'd101}};
		wait_oe(4'h0, 4);
		check("drv_off", off, 4'hF);
		check("irq", irq, 1'b1);
		rd(REG_STATUS, 32'h1);
		pulses(4095);
		rd(REG_STATE, 32'hF3);
		pulses(1);
		rd(REG_STATE, 32'hF1);
		wait_oe(4'hF, 30);
		wait_oe(4'h0, 4);
		@(posedge clk) cur <= '0;
		pulses(4096);
		wait_oe(4'hF, 30);
		apb(1'b1, REG_CTRL, 32'h0);
		wait_oe(4'h0, 4);
		rd(REG_STATE, 32'hF0);
		apb(1'b1, REG_CTRL, 32'h1);
		wait_oe(4'hF, 30);
		apb(1'b1, REG_IRQ_CLR, 32'h1);
		settle(1);
		check("irq", irq, 1'b0);
		@(posedge clk) cur <= 40'd200;
		pulses(7);
		@(posedge clk) cur <= 40'd200 << 10;
		pulses(1);
		@(posedge clk) cur <= 40'd200;
		pulses(7);
		settle(2);
		check("pwm_oe", poe, 4'hF);
		pulses(1);
		wait_oe(4'h0, 4);
		rd(REG_STATUS, 32'h2);
		@(posedge clk) begin
			en <= 1'b0;
			cur <= '0;
		end
		pulses(4096);
		settle(40);
		check("pwm_oe", poe, 4'h0);
		rd(REG_STATE, 32'hF0);
		apb(1'b1, REG_IRQ_CLR, 32'hF);
		apb(1'b1, REG_IRQ_EN, 32'hC);
		temp(8'd80, 1'b1, 1'b0);
		check("irq", irq, 1'b1);
		temp(8'd60, 1'b1, 1'b1);
		temp(8'd90, 1'b1, 1'b0);
		temp(8'd98, 1'b1, 1'b0);
		temp(8'd100, 1'b0, 1'b0);
		rd(REG_STATUS, 32'hC);
		conclude();
	end
endmodule
`default_nettype wire
